// ==== sim/discovery_host_model.sv ====
`timescale 1ns/1ps
module discovery_host_model (
   input  wire logic                           clk_i,
   output discovery_table_pkg::link_in_t       host_o,
   input  wire discovery_table_pkg::link_out_t dev_i
);
   initial host_o = 3'h2;
   // Released data line toggles so a stale bit never passes for data
   always @(posedge clk_i) if (host_o.cs_n) host_o.mosi <= ~host_o.mosi;
   task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int bits,
                        output logic [7:0] rd[$], output logic oe_seen);
      logic [39:0] hdr;
      logic [7:0]  b;
      hdr = {op, addr, 8'h00};
      rd = {};
      oe_seen = 1'b0;
      b = 8'h00;
      @(posedge clk_i) host_o.cs_n <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 40 + bits; i++) begin
         host_o.mosi <= (i < 40) ? hdr[39 - i] : ~host_o.mosi;
         repeat (4) @(posedge clk_i);
         host_o.sclk <= 1'b1;
         repeat (4) @(posedge clk_i);
         // Undriven line reads as the inverse so a missing enable shows as bad data
         b = {b[6:0], dev_i.miso_oe ? dev_i.miso : ~dev_i.miso};
         oe_seen |= dev_i.miso_oe;
         if (i >= 40 && i % 8 == 7) rd.push_back(b);
         host_o.sclk <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      host_o.cs_n <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// ==== sim/discovery_param_table_rom_test.sv ====
`timescale 1ns/1ps
`define CHECK(what, seen, exp) begin tests_run++; if ((seen) !== (exp)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", what, exp, seen); end end
module discovery_param_table_rom_test;
   logic                           ref_clk_i;
   logic                           sys_rst_i;
   discovery_table_pkg::link_in_t  link_i;
   discovery_table_pkg::link_out_t link_o;
   int                             n_errors;
   int                             tests_run;
   logic [7:0]                     rd[$];
   logic                           oe_seen;
   discovery_param_table_rom dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link_i(link_i), .link_o(link_o));
   discovery_host_model host (.clk_i(ref_clk_i), .host_o(link_i), .dev_i(link_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic t_basic_table;
      logic [7:0] exp[12] = '{8'hE5, 8'h20, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h44, 8'hEB, 8'h08, 8'h6B};
      host.frame(8'h5A, 24'h000030, 96, rd, oe_seen);
      for (int i = 0; i < 12; i++) `CHECK("table byte", rd[i], exp[i])
      `CHECK("1-4-4 dummies supported", rd[8][4:0] != 5'h00, 1'b1)
      `CHECK("1-1-4 mode bits none", rd[10][7:5], 3'h0)
   endtask
   task automatic t_header;
      host.frame(8'h5A, 24'h00000B, 16, rd, oe_seen);
      `CHECK("table length", rd[0], 8'h09)
      `CHECK("table pointer", rd[1], 8'h30)
   endtask
   task automatic t_bad_opcode;
      host.frame(8'h03, 24'h000030, 16, rd, oe_seen);
      `CHECK("oe on foreign opcode", oe_seen, 1'b0)
   endtask
   // Abort mid-byte, then restart after the frame task's usual nine-cycle deselect gap
   task automatic t_abort_restart;
      host.frame(8'h5A, 24'h000039, 3, rd, oe_seen);
      `CHECK("oe after abort", link_o.miso_oe, 1'b0)
      host.frame(8'h5A, 24'h00003B, 8, rd, oe_seen);
      `CHECK("byte after restart", rd[0], 8'h6B)
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      n_errors = 0;
      tests_run = 0;
      sys_rst_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      `CHECK("oe in reset", link_o.miso_oe, 1'b0)
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      t_basic_table();
      t_header();
      t_bad_opcode();
      t_abort_restart();
      report_and_stop();
   end
endmodule

// ==== sim/discovery_table_monitor.sv ====
`timescale 1ns/1ps
module discovery_table_monitor (
   input wire logic                           ref_clk_i,
   input wire logic                           sys_rst_i,
   input wire discovery_table_pkg::link_in_t  link_i,
   input wire discovery_table_pkg::link_out_t link_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic       sclk_q;
   logic [5:0] rises;
   logic [5:0] next_rises;
   // Pin-side rise count; the design sees each rise a few cycles later
   always_comb begin
      next_rises = rises;
      if (link_i.cs_n)
         next_rises = 6'h00;
      else if (link_i.sclk && !sclk_q && rises != 6'h3F)
         next_rises = rises + 6'h01;
   end
   always_ff @(posedge ref_clk_i) begin
      sclk_q <= link_i.sclk;
      rises  <= sys_rst_i ? 6'h00 : next_rises;
   end
   property p_idle; link_i.cs_n [*7] |-> !link_o.miso_oe; endproperty
   a_idle: assert property (p_idle) else $error("oe while deselected");
   property p_first; $rose(link_o.miso_oe) |-> rises == 6'h28 || rises == 6'h29; endproperty
   a_first: assert property (p_first) else $error("oe not after 40 rises");
   property p_drop; $rose(link_i.cs_n) |-> ##[1:6] !link_o.miso_oe; endproperty
   a_drop: assert property (p_drop) else $error("oe held after deselect");
   property p_rise_low; $rose(link_o.miso_oe) |-> !$past(link_i.sclk, 3); endproperty
   a_rise_low: assert property (p_rise_low) else $error("oe not after falling sclk");
   property p_shift; link_o.miso_oe && $past(link_o.miso_oe) && $changed(link_o.miso) |-> !$past(link_i.sclk, 2);
   endproperty
   a_shift: assert property (p_shift) else $error("miso moved in high phase");
   property p_hold; (link_i.sclk && link_o.miso_oe) [*3] |-> $stable(link_o.miso); endproperty
   a_hold: assert property (p_hold) else $error("miso unstable while sampled");
   property p_stream; link_o.miso_oe && !link_i.cs_n |=> link_o.miso_oe; endproperty
   a_stream: assert property (p_stream) else $error("output stopped mid frame");
   property p_fall; $fell(link_o.miso_oe) |-> $past(link_i.cs_n, 2); endproperty
   a_fall: assert property (p_fall) else $error("oe fell while selected");
endmodule
bind discovery_param_table_rom discovery_table_monitor u_mon (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .link_i(link_i), .link_o(link_o));

// ==== verilog/discovery_param_table_rom.sv ====
`timescale 1ns/1ps
module discovery_param_table_rom (
   input  wire logic                          ref_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire discovery_table_pkg::link_in_t link_i,
   output discovery_table_pkg::link_out_t     link_o
);

   typedef enum logic [3:0] {
      ST_CMD   = 4'b0001,
      ST_ADDR  = 4'b0010,
      ST_DUMMY = 4'b0100,
      ST_DATA  = 4'b1000
   } phase_t;

   // Three-stage pin sampling; a change counts once stages two and three agree
   logic [2:0] sclk_sync;
   logic [2:0] cs_sync;
   logic [2:0] mosi_sync;
   logic       sclk_q;
   logic       cs_n_q;
   logic       mosi_q;
   logic       next_sclk_q;
   logic       next_cs_n_q;
   logic       next_mosi_q;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         mosi_sync <= 3'h0;
         sclk_q    <= 1'b0;
         cs_n_q    <= 1'b1;
         mosi_q    <= 1'b0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], link_i.sclk};
         cs_sync   <= {cs_sync[1:0], link_i.cs_n};
         mosi_sync <= {mosi_sync[1:0], link_i.mosi};
         sclk_q    <= next_sclk_q;
         cs_n_q    <= next_cs_n_q;
         mosi_q    <= next_mosi_q;
      end
   end

   always_comb begin
      next_sclk_q = (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_q;
      next_cs_n_q = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_n_q;
      next_mosi_q = (mosi_sync[1] == mosi_sync[2]) ? mosi_sync[2] : mosi_q;
   end

   logic rise;
   logic fall;
   assign rise = next_sclk_q & ~sclk_q;
   assign fall = ~next_sclk_q & sclk_q;

   // Table lookup; only the header and first basic-table part are populated
   function automatic logic [7:0] table_byte(input logic [7:0] a);
      unique case (a)
         discovery_table_pkg::HDR_LEN_ADDR: table_byte = discovery_table_pkg::BASIC_TABLE_LEN_DW;
         discovery_table_pkg::HDR_PTR_ADDR: table_byte = discovery_table_pkg::BASIC_TABLE_PTR;
         discovery_table_pkg::BASIC_TABLE_PTR: table_byte = {discovery_table_pkg::BYTE30_FIXED_ONES,
                              discovery_table_pkg::VOL_WREN_OPC_SEL,
                              discovery_table_pkg::VOL_WREN_REQUIRED,
                              discovery_table_pkg::WRITE_GRAN_64,
                              discovery_table_pkg::ERASE_4K_CODE};
         discovery_table_pkg::ERASE_OPC_ADDR: table_byte = discovery_table_pkg::ERASE_4K_OPCODE;
         discovery_table_pkg::FEATURE_ADDR: table_byte = {discovery_table_pkg::BYTE32_SPARE,
                              discovery_table_pkg::READ_114_SUPPORTED,
                              discovery_table_pkg::READ_144_SUPPORTED,
                              discovery_table_pkg::READ_122_SUPPORTED,
                              discovery_table_pkg::DTR_SUPPORTED,
                              discovery_table_pkg::ADDR_MODE_3_OR_4,
                              discovery_table_pkg::READ_112_SUPPORTED};
         discovery_table_pkg::READ_144_CFG_ADDR:
            table_byte = {discovery_table_pkg::READ_144_MODE, discovery_table_pkg::READ_144_WAIT};
         discovery_table_pkg::READ_144_OPC_ADDR: table_byte = discovery_table_pkg::READ_144_OPCODE;
         discovery_table_pkg::READ_114_CFG_ADDR:
            table_byte = {discovery_table_pkg::READ_114_MODE, discovery_table_pkg::READ_114_WAIT};
         discovery_table_pkg::READ_114_OPC_ADDR: table_byte = discovery_table_pkg::READ_114_OPCODE;
         default: table_byte = discovery_table_pkg::UNUSED_BYTE;
      endcase
   endfunction

   phase_t     phase;
   phase_t     next_phase;
   logic [7:0] shift_in;
   logic [7:0] next_shift_in;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [1:0] byte_cnt;
   logic [1:0] next_byte_cnt;
   logic [7:0] addr;
   logic [7:0] next_addr;
   logic [7:0] shift_out;
   logic [7:0] next_shift_out;
   logic       active;
   logic       next_active;
   logic       drive;
   logic       next_drive;

   always_comb begin
      next_phase     = phase;
      next_shift_in  = shift_in;
      next_bit_cnt   = bit_cnt;
      next_byte_cnt  = byte_cnt;
      next_addr      = addr;
      next_shift_out = shift_out;
      next_active    = active;
      next_drive     = drive;
      if (next_cs_n_q) begin
         // Deselect ends the read at any point
         next_phase    = ST_CMD;
         next_bit_cnt  = 3'h0;
         next_byte_cnt = 2'h0;
         next_active   = 1'b1;
         next_drive    = 1'b0;
      end else if (rise && phase != ST_DATA) begin
         next_shift_in = {shift_in[6:0], next_mosi_q};
         next_bit_cnt  = bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            unique case (phase)
               ST_CMD: begin
                  // Other opcodes are ignored until the next frame
                  next_active = active && ({shift_in[6:0], next_mosi_q} ==
                                           discovery_table_pkg::CMD_READ_DISCOVERY_TABLE);
                  next_phase  = ST_ADDR;
               end
               ST_ADDR: begin
                  // Only the low address byte selects; upper bytes are don't care
                  next_addr     = {shift_in[6:0], next_mosi_q};
                  next_byte_cnt = byte_cnt + 2'h1;
                  if (byte_cnt == 2'(discovery_table_pkg::ADDR_BYTES - 1)) begin
                     next_phase = ST_DUMMY;
                  end
               end
               ST_DUMMY: begin
                  next_phase     = ST_DATA;
                  next_shift_out = table_byte(addr);
               end
               default: next_phase = ST_CMD;
            endcase
         end
      end else if (fall && phase == ST_DATA && active) begin
         // Output changes on falling edge so host samples on rising
         next_drive     = 1'b1;
         next_bit_cnt   = bit_cnt + 3'h1;
         if (drive) begin
            next_shift_out = {shift_out[6:0], 1'b0};
            if (bit_cnt == 3'h7) begin
               next_addr      = addr + 8'h01;
               next_shift_out = table_byte(addr + 8'h01);
            end
         end else begin
            next_bit_cnt = 3'h0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         phase     <= ST_CMD;
         shift_in  <= 8'h00;
         bit_cnt   <= 3'h0;
         byte_cnt  <= 2'h0;
         addr      <= 8'h00;
         shift_out <= 8'h00;
         active    <= 1'b1;
         drive     <= 1'b0;
      end else begin
         phase     <= next_phase;
         shift_in  <= next_shift_in;
         bit_cnt   <= next_bit_cnt;
         byte_cnt  <= next_byte_cnt;
         addr      <= next_addr;
         shift_out <= next_shift_out;
         active    <= next_active;
         drive     <= next_drive;
      end
   end

   assign link_o.miso    = shift_out[7];
   assign link_o.miso_oe = drive;

endmodule

// ==== verilog/discovery_table_pkg.sv ====
package discovery_table_pkg;

   // Command and framing
   localparam logic [7:0] CMD_READ_DISCOVERY_TABLE = 8'h5A;
   localparam int         ADDR_BYTES               = 3;
   localparam int         DUMMY_BYTES              = 1;

   // Header pointer and length of the basic parameter table
   localparam logic [7:0] BASIC_TABLE_PTR          = 8'h30;
   localparam logic [7:0] BASIC_TABLE_LEN_DW       = 8'h09;
   localparam logic [7:0] HDR_PTR_ADDR             = 8'h0C;
   localparam logic [7:0] HDR_LEN_ADDR             = 8'h0B;

   // Byte offsets inside the basic table; the first byte sits at the table pointer
   localparam logic [7:0] ERASE_OPC_ADDR           = 8'h31;
   localparam logic [7:0] FEATURE_ADDR             = 8'h32;
   localparam logic [7:0] READ_144_CFG_ADDR        = 8'h38;
   localparam logic [7:0] READ_144_OPC_ADDR        = 8'h39;
   localparam logic [7:0] READ_114_CFG_ADDR        = 8'h3A;
   localparam logic [7:0] READ_114_OPC_ADDR        = 8'h3B;

   // Byte 30h fields and the byte 31h erase opcode
   localparam logic [1:0] ERASE_4K_CODE            = 2'h1;
   localparam logic       WRITE_GRAN_64            = 1'h1;
   localparam logic       VOL_WREN_REQUIRED        = 1'h0;
   localparam logic       VOL_WREN_OPC_SEL         = 1'h0;
   localparam logic [2:0] BYTE30_FIXED_ONES        = 3'h7;
   localparam logic [7:0] ERASE_4K_OPCODE          = 8'h20;

   // Byte 32h fields
   localparam logic       READ_112_SUPPORTED       = 1'h1;
   localparam logic [1:0] ADDR_MODE_3_OR_4         = 2'h1;
   localparam logic       DTR_SUPPORTED            = 1'h0;
   localparam logic       READ_122_SUPPORTED       = 1'h1;
   localparam logic       READ_144_SUPPORTED       = 1'h1;
   localparam logic       READ_114_SUPPORTED       = 1'h1;
   localparam logic       BYTE32_SPARE             = 1'h1;

   // Fast-read wait states, mode bits and opcodes
   localparam logic [4:0] READ_144_WAIT            = 5'h04;
   localparam logic [2:0] READ_144_MODE            = 3'h2;
   localparam logic [7:0] READ_144_OPCODE          = 8'hEB;
   localparam logic [4:0] READ_114_WAIT            = 5'h08;
   localparam logic [2:0] READ_114_MODE            = 3'h0;
   localparam logic [7:0] READ_114_OPCODE          = 8'h6B;

   localparam logic [7:0] UNUSED_BYTE              = 8'hFF;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } link_in_t;

   typedef struct packed {
      logic miso;
      logic miso_oe;
   } link_out_t;

endpackage
